//--- rtl/iemsk_top.v
// interrupt enable masks two to four with pending flags and per-source priority; sources 24..47 fixed at four
// assumes a same-clock register port; read data valid the cycle after the strobe
// Behaviour
// - enable one passes request, zero holds off
// - implemented enables read/write, reset to zero
// - unused bits ignore writes, read zero
// - mask two upper byte source mapping
// - mask two lower byte source mapping
// - mask three upper byte source mapping
// - mask three lower byte source mapping
// - mask four source mapping
// - priority zero disables; seven is highest
//
// Implementation choices: the register addresses and strobed register access.
`include "iemsk_defs.vh"
module iemsk_top (
  input  wire        mclk_in,
  input  wire        nrst_in,
  input  wire [3:0]  addr_in,
  input  wire [15:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  input  wire [15:0] src_two_in,
  input  wire [15:0] src_three_in,
  input  wire [15:0] src_four_in,
  output reg  [15:0] rdata_out,
  output reg  [47:0] irq_req_out,
  output reg  [2:0]  irq_prio_out,
  output reg         irq_any_out
);
  // source bit positions are the mask bit positions:
  // two: 15 timer6, 14 dma4, 12..9 outcmp8..5, 8..6 incap6..4 ... see below
  // two: 5 incap3, 4 dma3, 3 can1 event, 2 can1 rx, 1 spi2 event, 0 spi2 error
  // three: 15 fault a, 13 dma5, 10 quad enc, 9 pwm err, 8 can2, 7 can2 rx,
  //        6 ext4, 5 ext3, 4 timer9, 3 timer8, 2 i2c2 master, 1 i2c2 slave, 0 timer7
  // four: 7 can2 tx, 6 can1 tx, 5 dma7, 4 dma6, 2 uart2 err, 1 uart1 err, 0 fault b
  reg  [15:0] irq_enable_mask_two_r;
  reg  [15:0] irq_enable_mask_three_r;
  reg  [15:0] irq_enable_mask_four_r;
  reg  [2:0]  prio_r [0:47];
  reg  [15:0] rdata_nxt;
  reg  [47:0] prio_nz;
  reg  [2:0]  best_nxt;
  wire [47:0] pend;
  wire [47:0] req;
  wire [47:0] impl_all;
  wire [47:0] ev_all;
  wire [47:0] en_all;
  wire [47:0] clr_all;
  wire        wr_pend_two;
  wire        wr_pend_three;
  wire        wr_pend_four;
  integer     i;
  integer     j;
  integer     k;
  // one enable per source, named by what it gates
  wire        timer6_irq_en;
  wire        dma_ch4_done_irq_en;
  wire        outcmp8_irq_en;
  wire        outcmp7_irq_en;
  wire        outcmp6_irq_en;
  wire        outcmp5_irq_en;
  wire        incap6_irq_en;
  wire        incap5_irq_en;
  wire        incap4_irq_en;
  wire        incap3_irq_en;
  wire        dma_ch3_done_irq_en;
  wire        can1_event_irq_en;
  wire        can1_rx_ready_irq_en;
  wire        spi2_event_irq_en;
  wire        spi2_error_irq_en;
  wire        pwm_fault_a_irq_en;
  wire        dma_ch5_done_irq_en;
  wire        quad_encoder_irq_en;
  wire        pwm_error_irq_en;
  wire        can2_event_irq_en;
  wire        can2_rx_ready_irq_en;
  wire        ext_pin4_irq_en;
  wire        ext_pin3_irq_en;
  wire        timer9_irq_en;
  wire        timer8_irq_en;
  wire        i2c2_master_irq_en;
  wire        i2c2_slave_irq_en;
  wire        timer7_irq_en;
  wire        can2_tx_request_irq_en;
  wire        can1_tx_request_irq_en;
  wire        dma_ch7_done_irq_en;
  wire        dma_ch6_done_irq_en;
  wire        uart2_error_irq_en;
  wire        uart1_error_irq_en;
  wire        pwm_fault_b_irq_en;

  function [15:0] impl_of;
    input [1:0] grp;
    begin
      case (grp)
        2'h0:    impl_of = `IEMSK_IMPL_TWO;
        2'h1:    impl_of = `IEMSK_IMPL_THREE;
        2'h2:    impl_of = `IEMSK_IMPL_FOUR;
        default: impl_of = 16'h0000;
      endcase
    end
  endfunction

  function hit;
    input [3:0] a;
    input [3:0] idx;
    begin
      hit = (a == idx);
    end
  endfunction

  assign impl_all = {impl_of(2'h2), impl_of(2'h1), impl_of(2'h0)};
  assign ev_all   = {src_four_in, src_three_in, src_two_in};
  // named enables keep the bit map in one place; unused positions tie low
  assign timer6_irq_en          = irq_enable_mask_two_r[15];
  assign dma_ch4_done_irq_en    = irq_enable_mask_two_r[14];
  assign outcmp8_irq_en         = irq_enable_mask_two_r[12];
  assign outcmp7_irq_en         = irq_enable_mask_two_r[11];
  assign outcmp6_irq_en         = irq_enable_mask_two_r[10];
  assign outcmp5_irq_en         = irq_enable_mask_two_r[9];
  assign incap6_irq_en          = irq_enable_mask_two_r[8];
  assign incap5_irq_en          = irq_enable_mask_two_r[7];
  assign incap4_irq_en          = irq_enable_mask_two_r[6];
  assign incap3_irq_en          = irq_enable_mask_two_r[5];
  assign dma_ch3_done_irq_en    = irq_enable_mask_two_r[4];
  assign can1_event_irq_en      = irq_enable_mask_two_r[3];
  assign can1_rx_ready_irq_en   = irq_enable_mask_two_r[2];
  assign spi2_event_irq_en      = irq_enable_mask_two_r[1];
  assign spi2_error_irq_en      = irq_enable_mask_two_r[0];
  assign pwm_fault_a_irq_en     = irq_enable_mask_three_r[15];
  assign dma_ch5_done_irq_en    = irq_enable_mask_three_r[13];
  assign quad_encoder_irq_en    = irq_enable_mask_three_r[10];
  assign pwm_error_irq_en       = irq_enable_mask_three_r[9];
  assign can2_event_irq_en      = irq_enable_mask_three_r[8];
  assign can2_rx_ready_irq_en   = irq_enable_mask_three_r[7];
  assign ext_pin4_irq_en        = irq_enable_mask_three_r[6];
  assign ext_pin3_irq_en        = irq_enable_mask_three_r[5];
  assign timer9_irq_en          = irq_enable_mask_three_r[4];
  assign timer8_irq_en          = irq_enable_mask_three_r[3];
  assign i2c2_master_irq_en     = irq_enable_mask_three_r[2];
  assign i2c2_slave_irq_en      = irq_enable_mask_three_r[1];
  assign timer7_irq_en          = irq_enable_mask_three_r[0];
  assign can2_tx_request_irq_en = irq_enable_mask_four_r[7];
  assign can1_tx_request_irq_en = irq_enable_mask_four_r[6];
  assign dma_ch7_done_irq_en    = irq_enable_mask_four_r[5];
  assign dma_ch6_done_irq_en    = irq_enable_mask_four_r[4];
  assign uart2_error_irq_en     = irq_enable_mask_four_r[2];
  assign uart1_error_irq_en     = irq_enable_mask_four_r[1];
  assign pwm_fault_b_irq_en     = irq_enable_mask_four_r[0];
  assign en_all   = {
    // mask four
    8'h00,
    can2_tx_request_irq_en,
    can1_tx_request_irq_en,
    dma_ch7_done_irq_en,
    dma_ch6_done_irq_en,
    1'h0,
    uart2_error_irq_en,
    uart1_error_irq_en,
    pwm_fault_b_irq_en,
    // mask three
    pwm_fault_a_irq_en,
    1'h0,
    dma_ch5_done_irq_en,
    2'h0,
    quad_encoder_irq_en,
    pwm_error_irq_en,
    can2_event_irq_en,
    can2_rx_ready_irq_en,
    ext_pin4_irq_en,
    ext_pin3_irq_en,
    timer9_irq_en,
    timer8_irq_en,
    i2c2_master_irq_en,
    i2c2_slave_irq_en,
    timer7_irq_en,
    // mask two
    timer6_irq_en,
    dma_ch4_done_irq_en,
    1'h0,
    outcmp8_irq_en,
    outcmp7_irq_en,
    outcmp6_irq_en,
    outcmp5_irq_en,
    incap6_irq_en,
    incap5_irq_en,
    incap4_irq_en,
    incap3_irq_en,
    dma_ch3_done_irq_en,
    can1_event_irq_en,
    can1_rx_ready_irq_en,
    spi2_event_irq_en,
    spi2_error_irq_en};
  assign wr_pend_two   = wr_in & hit(addr_in, `IEMSK_IDX_PEND_TWO);
  assign wr_pend_three = wr_in & hit(addr_in, `IEMSK_IDX_PEND_THREE);
  assign wr_pend_four  = wr_in & hit(addr_in, `IEMSK_IDX_PEND_FOUR);
  // pending flags clear by writing one to the bit
  assign clr_all = {wr_pend_four ? wdata_in : 16'h0000,
                    wr_pend_three ? wdata_in : 16'h0000,
                    wr_pend_two ? wdata_in : 16'h0000};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : grp
      iemsk_gate u_gate (
        .mclk_in     (mclk_in),
        .nrst_in     (nrst_in),
        .event_in    (ev_all[g*16 +: 16]),
        .enable_in   (en_all[g*16 +: 16]),
        .impl_in     (impl_all[g*16 +: 16]),
        .prio_nz_in  (prio_nz[g*16 +: 16]),
        .pend_clr_in (clr_all[g*16 +: 16]),
        .pend_out    (pend[g*16 +: 16]),
        .req_out     (req[g*16 +: 16])
      );
    end
  endgenerate

  // enable masks; unimplemented positions never store
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_enable_mask_two_r   <= `IEMSK_MASK_RST;
      irq_enable_mask_three_r <= `IEMSK_MASK_RST;
      irq_enable_mask_four_r  <= `IEMSK_MASK_RST;
    end else if (wr_in) begin
      if (hit(addr_in, `IEMSK_IDX_MASK_TWO)) begin
        irq_enable_mask_two_r <= wdata_in & `IEMSK_IMPL_TWO;
      end
      if (hit(addr_in, `IEMSK_IDX_MASK_THREE)) begin
        irq_enable_mask_three_r <= wdata_in & `IEMSK_IMPL_THREE;
      end
      if (hit(addr_in, `IEMSK_IDX_MASK_FOUR)) begin
        irq_enable_mask_four_r <= wdata_in & `IEMSK_IMPL_FOUR;
      end
    end
  end

  // priorities: index 8+k holds four 3-bit fields for sources 4k..4k+3,
  // each field in a nibble's low three bits
  // indices above the last priority word are unmapped and ignore writes
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (i = 0; i < 48; i = i + 1) begin
        prio_r[i] <= `IEMSK_PRIO_RST;
      end
    end else if (wr_in && addr_in >= `IEMSK_IDX_PRIO_BASE && addr_in <= 4'hD) begin
      for (i = 0; i < 48; i = i + 1) begin
        if ((i / 4) == ({28'h0, addr_in} - {28'h0, `IEMSK_IDX_PRIO_BASE}) && impl_all[i]) begin
          prio_r[i] <= wdata_in[(i % 4) * 4 +: 3];
        end
      end
    end
  end

  // highest enabled request priority; priority zero is never a request
  always @* begin
    prio_nz  = 48'h0;
    best_nxt = `IEMSK_PRIO_OFF;
    for (j = 0; j < 48; j = j + 1) begin
      prio_nz[j] = (prio_r[j] != `IEMSK_PRIO_OFF);
    end
    for (j = 0; j < 48; j = j + 1) begin
      if (req[j] && prio_r[j] > best_nxt) begin
        best_nxt = prio_r[j];
      end
    end
  end

  always @* begin
    rdata_nxt = 16'h0000;
    case (addr_in)
      `IEMSK_IDX_MASK_TWO:   rdata_nxt = irq_enable_mask_two_r;
      `IEMSK_IDX_MASK_THREE: rdata_nxt = irq_enable_mask_three_r;
      `IEMSK_IDX_MASK_FOUR:  rdata_nxt = irq_enable_mask_four_r;
      `IEMSK_IDX_PEND_TWO:   rdata_nxt = pend[15:0];
      `IEMSK_IDX_PEND_THREE: rdata_nxt = pend[31:16];
      `IEMSK_IDX_PEND_FOUR:  rdata_nxt = pend[47:32];
      default: begin
        if (addr_in >= `IEMSK_IDX_PRIO_BASE && addr_in <= 4'hD) begin
          for (k = 0; k < 48; k = k + 1) begin
            if ((k / 4) == ({28'h0, addr_in} - {28'h0, `IEMSK_IDX_PRIO_BASE})) begin
              rdata_nxt[(k % 4) * 4 +: 3] = impl_all[k] ? prio_r[k] : 3'h0;
            end
          end
        end
      end
    endcase
  end

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out    <= 16'h0000;
      irq_req_out  <= 48'h0;
      irq_prio_out <= `IEMSK_PRIO_OFF;
      irq_any_out  <= 1'b0;
    end else begin
      rdata_out    <= rd_in ? rdata_nxt : 16'h0000;
      irq_req_out  <= req;
      irq_prio_out <= best_nxt;
      irq_any_out  <= |req;
    end
  end
endmodule

//--- rtl/iemsk_defs.vh
// constants for the interrupt enable mask block (masks two to four)
// assumes a 16-bit register port with word indices and one 50 MHz clock
`ifndef IEMSK_DEFS_VH
`define IEMSK_DEFS_VH
`define IEMSK_ADDR_W        4
`define IEMSK_DATA_W        16
`define IEMSK_NSRC          48
`define IEMSK_PRIO_W        3
`define IEMSK_IDX_MASK_TWO   4'h0
`define IEMSK_IDX_MASK_THREE 4'h1
`define IEMSK_IDX_MASK_FOUR  4'h2
`define IEMSK_IDX_PEND_TWO   4'h3
`define IEMSK_IDX_PEND_THREE 4'h4
`define IEMSK_IDX_PEND_FOUR  4'h5
`define IEMSK_IDX_PRIO_BASE  4'h8
`define IEMSK_IMPL_TWO      16'hDFFF
`define IEMSK_IMPL_THREE    16'hA7FF
`define IEMSK_IMPL_FOUR     16'h00F7
`define IEMSK_MASK_RST      16'h0000
`define IEMSK_PRIO_RST      3'h4
`define IEMSK_PRIO_OFF      3'h0
`define IEMSK_PRIO_TOP      3'h7
`endif

//--- rtl/iemsk_gate.v
// one 16-bit group of sources: pending flags and enable/priority gating
// assumes event inputs are synchronous one-cycle pulses or levels on mclk_in
`include "iemsk_defs.vh"
module iemsk_gate (
  input  wire        mclk_in,
  input  wire        nrst_in,
  input  wire [15:0] event_in,
  input  wire [15:0] enable_in,
  input  wire [15:0] impl_in,
  input  wire [15:0] prio_nz_in,
  input  wire [15:0] pend_clr_in,
  output reg  [15:0] pend_out,
  output wire [15:0] req_out
);
  wire [15:0] pend_nxt;

  // set wins over a software clear landing in the same cycle
  assign pend_nxt = ((pend_out & ~pend_clr_in) | event_in) & impl_in;
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_out <= 16'h0000;
    end else begin
      pend_out <= pend_nxt;
    end
  end

  assign req_out = pend_out & enable_in & prio_nz_in & impl_in;
endmodule

//--- verification/iemsk_src_model.sv
// partner model: the peripheral sources, one event pulse per request
// assumes go_in changes just after a rising edge of mclk_in
module iemsk_src_model (
  input  wire         mclk_in,
  input  wire         go_in,
  input  wire  [5:0]  num_in,
  output logic [47:0] src_out = 48'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge mclk_in) src_out <= go_in ? (48'h1 << num_in) : 48'h0;
endmodule

//--- verification/iemsk_top_monitor.sv
// checker for the mask block: register reads and request outputs
// assumes the ports of iemsk_top and its single clock
`include "iemsk_defs.vh"
module iemsk_top_monitor (
  input wire        mclk_in,
  input wire        nrst_in,
  input wire [3:0]  addr_in,
  input wire [15:0] wdata_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire [15:0] rdata_out,
  input wire [47:0] irq_req_out,
  input wire [2:0]  irq_prio_out,
  input wire        irq_any_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  property p_rd_idle; !$past(rd_in) |-> rdata_out == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
  property p_rd_back;
    wr_in && addr_in == `IEMSK_IDX_MASK_TWO ##1 rd_in && addr_in == `IEMSK_IDX_MASK_TWO
      |=> rdata_out == ($past(wdata_in, 2) & `IEMSK_IMPL_TWO);
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("mask two read back wrong");
  property p_unused3;
    $past(rd_in && addr_in == `IEMSK_IDX_MASK_THREE) |-> (rdata_out & ~`IEMSK_IMPL_THREE) == 0;
  endproperty
  a_unused3: assert property (p_unused3) else $error("mask three unused bit set");
  property p_unused4;
    $past(rd_in && addr_in == `IEMSK_IDX_MASK_FOUR) |-> (rdata_out & ~`IEMSK_IMPL_FOUR) == 0;
  endproperty
  a_unused4: assert property (p_unused4) else $error("mask four unused bit set");
  property p_req_impl;
    (irq_req_out & ~{`IEMSK_IMPL_FOUR, `IEMSK_IMPL_THREE, `IEMSK_IMPL_TWO}) == 48'h0;
  endproperty
  a_req_impl: assert property (p_req_impl) else $error("request on unused source");
  property p_mask_off;
    wr_in && addr_in == `IEMSK_IDX_MASK_TWO && wdata_in == 16'h0000 |-> ##2 irq_req_out[15:0] == 0;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("request passes a cleared mask");
  property p_any; irq_any_out == (irq_req_out != 48'h0); endproperty
  a_any: assert property (p_any) else $error("any flag disagrees with requests");
  property p_prio; irq_any_out == (irq_prio_out != 3'h0); endproperty
  a_prio: assert property (p_prio) else $error("priority disagrees with any flag");
  cover property (irq_prio_out == 3'h7);
  cover property (irq_any_out ##1 !irq_any_out);
  cover property (rd_in && addr_in == `IEMSK_IDX_MASK_FOUR);
endmodule
bind iemsk_top iemsk_top_monitor mon (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .irq_req_out(irq_req_out), .irq_prio_out(irq_prio_out), .irq_any_out(irq_any_out));

//--- verification/iemsk_top_tb.sv
// self-checking bench for the mask block with the source model
// assumes iemsk_top, iemsk_src_model and the checker compiled first
`include "iemsk_defs.vh"
module iemsk_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in = 0, nrst_in = 0, wr = 0, rd = 0, go = 0, any;
  logic [3:0]  addr = 4'h0;
  logic [5:0]  num = 6'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [47:0] src, req;
  logic [2:0]  prio;
  logic [47:0] impl = {`IEMSK_IMPL_FOUR, `IEMSK_IMPL_THREE, `IEMSK_IMPL_TWO};
  int          error_cnt = 0, cmp_count = 0, cyc = 0, i;
  iemsk_top uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .src_two_in(src[15:0]), .src_three_in(src[31:16]),
    .src_four_in(src[47:32]), .rdata_out(rdata), .irq_req_out(req), .irq_prio_out(prio),
    .irq_any_out(any));
  iemsk_src_model srcs (.mclk_in(mclk_in), .go_in(go), .num_in(num), .src_out(src));
  initial forever #10 mclk_in = ~mclk_in;
  // tasks are entered and left at a rising edge; results are read at the falling edge
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    @(negedge mclk_in);
    cmp_count++;
    if (rdata !== e) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, rdata, e);
    end
    @(posedge mclk_in);
  endtask
  task automatic fire(input logic [5:0] n);
    go <= 1'b1;
    num <= n;
    @(posedge mclk_in);
    go <= 1'b0;
  endtask
  task automatic chk_irq(input logic [47:0] e, input logic [2:0] p);
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    cmp_count++;
    if ({any, prio, req} !== {|e, p, e}) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, {any, prio, req}, {|e, p, e});
    end
    @(posedge mclk_in);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    nrst_in <= 1'b1;
    for (i = 0; i < 3; i++) chk_reg(4'(i), 16'h0000);
    chk_reg(`IEMSK_IDX_PRIO_BASE, 16'h4444);
    chk_reg(4'hB, 16'h4404);
    for (i = 0; i < 3; i++) begin
      wr_reg(4'(i), 16'hFFFF);
      chk_reg(4'(i), impl[16*i +: 16]);
    end
    wr_reg(4'h6, 16'hFFFF);
    chk_reg(4'h6, 16'h0000);
    $display("register test done");
    for (i = 0; i < 48; i++) begin
      fire(6'(i));
      chk_irq(impl & (48'h1 << i), impl[i] ? 3'h4 : 3'h0);
      wr_reg(4'(`IEMSK_IDX_PEND_TWO + i / 16), 16'hFFFF);
    end
    $display("source map test done");
    wr_reg(`IEMSK_IDX_MASK_TWO, 16'h0000);
    fire(6'h00);
    chk_irq(48'h0, 3'h0);
    chk_reg(`IEMSK_IDX_PEND_TWO, 16'h0001);
    wr_reg(`IEMSK_IDX_MASK_TWO, 16'h0001);
    chk_irq(48'h1, 3'h4);
    $display("gating test done");
    wr_reg(`IEMSK_IDX_PRIO_BASE, 16'h4447);
    chk_irq(48'h1, 3'h7);
    wr_reg(`IEMSK_IDX_PRIO_BASE, 16'h4440);
    chk_irq(48'h0, 3'h0);
    wr_reg(4'hE, 16'h0000);
    chk_reg(4'hE, 16'h0000);
    fire(6'h18);
    chk_irq(48'h000001000000, 3'h4);
    $display("priority test done");
    wrap_up();
  end
endmodule
